// *** rtl/spi_pkg.sv ***
// Purpose: Shared constants and types for the serial port block
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes:   Only the phase-zero format with idle-low clock is built
//
// Functional notes
// - All divider bits clear divides by two
// - Divisor is (prescale+1) times 2^(rate+1)
// - Prescale multiplies rate divisor for odd ratios
// - Divider runs only during controller transfers
// - Auto select low in transfer, high idle
// - Auto select needs controller, both enables
// - Auto select disables mode fault detection
// - Single wire uses MOSI controller, MISO peripheral
// - Single-wire direction bit; pin feeds shifter
// - Clock out in controller, in otherwise
// - Select low in controller sets fault
// - No fault without enable or in peripheral
// - Fault forces peripheral, outputs off, abort
// - Fault in single wire clears out enable
// - After fault in single wire MISO becomes the data pin
// - Status read then control write clears fault
// - System enable clear holds core idle
// - Stop-in-wait clear keeps normal operation
// - Controller freezes in wait, resumes after
// - Peripheral keeps shifting during wait
// - Peripheral done and copy deferred past wait
// - Deferred done only for transfers ending in wait
// - Done flag half clock after last edge in controller, later at divide-by-two; at last edge in peripheral
// - Phase zero: sixteen edges, odd latch, even shift

package spi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL1  = 5'h00;
  localparam logic [4:0] OFS_CTRL2  = 5'h04;
  localparam logic [4:0] OFS_BAUD   = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_DATA   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_ENABLE      = 6;
  localparam int C1_CONTROLLER  = 4;
  localparam int C1_SELECT_OUT  = 1;
  localparam int C2_FAULT_DET   = 4;
  localparam int C2_SW_OUT_EN   = 3;
  localparam int C2_STOP_WAIT   = 1;
  localparam int C2_SW_SELECT   = 0;
  localparam int BAUD_PRE_LSB   = 4;
  localparam int BAUD_RATE_LSB  = 0;
  localparam int SR_DONE        = 7;
  localparam int SR_TX_EMPTY    = 5;
  localparam int SR_FAULT       = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic       BIT_RST      = 1'b0;
  localparam logic [2:0] PRESCALE_RST = 3'h0;
  localparam logic [2:0] RATE_RST     = 3'h0;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [4:0] EDGE_RST     = 5'h00;
  localparam logic [4:0] LAST_EDGE    = 5'h0F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_RUN   = 4'h4,
    ST_TRAIL = 4'h8
  } xfer_state_e;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } pin_in_s;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss_n;
    logic ss_n_oe;
  } pin_out_s;

endpackage : spi_pkg

// *** rtl/baud_div.sv ***
// Purpose: Half-period tick generator for the serial clock
// Assumes: Tick marks one serial clock edge
// Notes:   Counter is held at zero whenever run is low

`timescale 1ns/1ps

module baud_div (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] prescale,
  input  wire logic [2:0] rate,
  // Edge tick
  output logic            tick
);

  logic [10:0] half;
  logic [10:0] cnt_q;

  assign half = ({8'h00, prescale} + 11'h001) << rate;
  assign tick = run && (cnt_q == half - 11'h001);

  always_ff @(posedge clk) begin
    if (!reset_n || !run || tick) begin
      cnt_q <= 11'h000;
    end else begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_div_by_two: assert property (@(posedge clk) disable iff (!reset_n)
    (run && prescale == 3'h0 && rate == 3'h0) |-> tick)
    else $error("default divider does not tick every cycle");

  chk_div_spacing: assert property (@(posedge clk) disable iff (!reset_n)
    (run && tick && half != 11'h001) |=> !tick)
    else $error("divider ticks too close together");

  chk_div_held: assert property (@(posedge clk) disable iff (!reset_n)
    (!run) |=> (cnt_q == 11'h000))
    else $error("divider counts while not running");

endmodule : baud_div

// *** rtl/spi_port.sv ***
// Purpose: Serial port core with Avalon-MM register slave
// Assumes: Pins and cpu_wait enter as listed; pins are resolved outside
// Notes:   One-cycle waitrequest answer; phase-zero format, idle-low clock

`timescale 1ns/1ps

module spi_port (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [4:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // Processor wait state
  input  wire logic              cpu_wait,
  // Serial pins
  input  wire spi_pkg::pin_in_s  pins_in,
  output spi_pkg::pin_out_s      pins
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 en_q, ctrl_q, sso_q;
  logic                 mfen_q, swoe_q, siw_q, sws_q;
  logic [2:0]           prescale_q, rate_q;
  logic                 fault_q, fault_seen_q, done_q, done_seen_q;
  logic                 tx_full_q, pend_q;
  logic [7:0]           tx_buf_q, rx_buf_q, sreg_q;
  logic                 latch_q, sck_q;
  logic [4:0]           cnt_q;
  spi_pkg::xfer_state_e st_q;
  spi_pkg::pin_in_s     sync1_q, in_s;
  logic                 sck_prev_q, ss_prev_q;
  logic                 wr_go, rd_go;
  logic                 wr_c1, wr_c2, wr_baud, wr_data, rd_status, rd_data;
  logic [31:0]          rd_val;
  logic                 frz, run_ctl, tick, start, c_edge, c_latch, c_shift;
  logic                 c_done, p_sel, ss_fall, p_rise, p_fall, p_done;
  logic                 fault_set, done_set, din;
  logic [2:0]           lat_dly_q;
  logic [7:0]           crx_q;
  spi_pkg::pin_out_s    pins_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
      in_s    <= '{sck: 1'b0, ss_n: 1'b1, mosi: 1'b0, miso: 1'b0};
    end else begin
      sync1_q <= pins_in;
      in_s    <= sync1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sck_prev_q <= 1'b0;
      ss_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= in_s.sck;
      ss_prev_q  <= in_s.ss_n;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  assign wr_go = write && !waitrequest;
  assign rd_go = read && !waitrequest;

  always_comb begin
    wr_c1     = 1'b0;
    wr_c2     = 1'b0;
    wr_baud   = 1'b0;
    wr_data   = 1'b0;
    rd_status = 1'b0;
    rd_data   = 1'b0;
    if (address == spi_pkg::OFS_CTRL1) begin
      wr_c1 = wr_go;
    end else if (address == spi_pkg::OFS_CTRL2) begin
      wr_c2 = wr_go;
    end else if (address == spi_pkg::OFS_BAUD) begin
      wr_baud = wr_go;
    end else if (address == spi_pkg::OFS_STATUS) begin
      rd_status = rd_go;
    end else if (address == spi_pkg::OFS_DATA) begin
      wr_data = wr_go;
      rd_data = rd_go;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (address == spi_pkg::OFS_CTRL1) begin
      rd_val[spi_pkg::C1_ENABLE]     = en_q;
      rd_val[spi_pkg::C1_CONTROLLER] = ctrl_q;
      rd_val[spi_pkg::C1_SELECT_OUT] = sso_q;
    end else if (address == spi_pkg::OFS_CTRL2) begin
      rd_val[spi_pkg::C2_FAULT_DET] = mfen_q;
      rd_val[spi_pkg::C2_SW_OUT_EN] = swoe_q;
      rd_val[spi_pkg::C2_STOP_WAIT] = siw_q;
      rd_val[spi_pkg::C2_SW_SELECT] = sws_q;
    end else if (address == spi_pkg::OFS_BAUD) begin
      rd_val[spi_pkg::BAUD_PRE_LSB +: 3]  = prescale_q;
      rd_val[spi_pkg::BAUD_RATE_LSB +: 3] = rate_q;
    end else if (address == spi_pkg::OFS_STATUS) begin
      rd_val[spi_pkg::SR_DONE]     = done_q;
      rd_val[spi_pkg::SR_TX_EMPTY] = !tx_full_q;
      rd_val[spi_pkg::SR_FAULT]    = fault_q;
    end else if (address == spi_pkg::OFS_DATA) begin
      rd_val[7:0] = rx_buf_q;
    end
  end

  // Answer one cycle after the request is seen
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        readdata <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_q   <= spi_pkg::BIT_RST;
      ctrl_q <= spi_pkg::BIT_RST;
      sso_q  <= spi_pkg::BIT_RST;
    end else begin
      if (wr_c1) begin
        en_q   <= writedata[spi_pkg::C1_ENABLE];
        ctrl_q <= writedata[spi_pkg::C1_CONTROLLER];
        sso_q  <= writedata[spi_pkg::C1_SELECT_OUT];
      end
      if (fault_set) begin
        ctrl_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mfen_q <= spi_pkg::BIT_RST;
      swoe_q <= spi_pkg::BIT_RST;
      siw_q  <= spi_pkg::BIT_RST;
      sws_q  <= spi_pkg::BIT_RST;
    end else begin
      if (wr_c2) begin
        mfen_q <= writedata[spi_pkg::C2_FAULT_DET];
        swoe_q <= writedata[spi_pkg::C2_SW_OUT_EN];
        siw_q  <= writedata[spi_pkg::C2_STOP_WAIT];
        sws_q  <= writedata[spi_pkg::C2_SW_SELECT];
      end
      if (fault_set && sws_q) begin
        swoe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prescale_q <= spi_pkg::PRESCALE_RST;
      rate_q     <= spi_pkg::RATE_RST;
    end else if (wr_baud) begin
      prescale_q <= writedata[spi_pkg::BAUD_PRE_LSB +: 3];
      rate_q     <= writedata[spi_pkg::BAUD_RATE_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_buf_q  <= spi_pkg::DATA_RST;
      tx_full_q <= spi_pkg::BIT_RST;
    end else begin
      if (wr_data) begin
        tx_buf_q <= writedata[7:0];
      end
      if (wr_data) begin
        tx_full_q <= 1'b1;
      end else if (start || ss_fall) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode fault
  // ----------------------------------------------------------------
  // fault only in detecting controller
  assign fault_set = en_q && ctrl_q && mfen_q && !sso_q && !in_s.ss_n;

  // read then write clears, a new fault wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_q      <= spi_pkg::BIT_RST;
      fault_seen_q <= spi_pkg::BIT_RST;
    end else begin
      if (fault_set) begin
        fault_q <= 1'b1;
      end else if (wr_c1 && fault_seen_q) begin
        fault_q <= 1'b0;
      end
      if (rd_status && fault_q) begin
        fault_seen_q <= 1'b1;
      end else if (wr_c1 || !fault_q) begin
        fault_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Controller sequencing
  // ----------------------------------------------------------------
  // freeze only with stop-in-wait
  assign frz     = siw_q && cpu_wait;
  // divider gated to active controller transfers
  assign run_ctl = en_q && ctrl_q && (st_q != spi_pkg::ST_IDLE) && !frz;
  assign start   = en_q && ctrl_q && !fault_q && tx_full_q && (st_q == spi_pkg::ST_IDLE);
  assign c_edge  = (st_q == spi_pkg::ST_RUN) && tick;
  // odd edges latch, even edges shift
  assign c_latch = c_edge && !cnt_q[0];
  assign c_shift = c_edge && cnt_q[0];
  assign c_done  = (st_q == spi_pkg::ST_TRAIL) && tick && (lat_dly_q == 3'h0);

  baud_div u_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (run_ctl),
    .prescale (prescale_q),
    .rate     (rate_q),
    .tick     (tick)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q  <= spi_pkg::ST_IDLE;
      sck_q <= 1'b0;
    end else if (fault_set || !en_q) begin
      st_q  <= spi_pkg::ST_IDLE;
      sck_q <= 1'b0;
    end else begin
      case (st_q)
        spi_pkg::ST_IDLE: begin
          if (start) begin
            st_q <= spi_pkg::ST_LEAD;
          end
        end
        spi_pkg::ST_LEAD: begin
          if (tick) begin
            st_q <= spi_pkg::ST_RUN;
          end
        end
        spi_pkg::ST_RUN: begin
          if (tick) begin
            sck_q <= !sck_q;
            if (cnt_q == spi_pkg::LAST_EDGE) begin
              st_q <= spi_pkg::ST_TRAIL;
            end
          end
        end
        spi_pkg::ST_TRAIL: begin
          // done half a period after last edge
          // Limitation: at divide-by-two it also waits for the late sample
          if (c_done) begin
            st_q <= spi_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= spi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peripheral edges and shifter
  // ----------------------------------------------------------------
  assign p_sel   = en_q && !ctrl_q && !in_s.ss_n;
  assign ss_fall = en_q && !ctrl_q && ss_prev_q && !in_s.ss_n;
  assign p_rise  = p_sel && !sck_prev_q && in_s.sck;
  assign p_fall  = p_sel && sck_prev_q && !in_s.sck;
  assign p_done  = p_fall && (cnt_q == spi_pkg::LAST_EDGE);

  // data pin follows role and wire mode
  assign din = ctrl_q ? (sws_q ? in_s.mosi : in_s.miso)
                      : (sws_q ? in_s.miso : in_s.mosi);

  // peripheral shifting continues in wait; reselect sends buffer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sreg_q  <= spi_pkg::DATA_RST;
      latch_q <= 1'b0;
      cnt_q   <= spi_pkg::EDGE_RST;
    end else if (start || ss_fall) begin
      sreg_q <= tx_buf_q;
      cnt_q  <= spi_pkg::EDGE_RST;
    end else if (c_latch || p_rise) begin
      latch_q <= din;
      cnt_q   <= cnt_q + 5'h01;
    end else if (c_shift || p_fall) begin
      sreg_q <= {sreg_q[6:0], latch_q};
      cnt_q  <= p_done ? spi_pkg::EDGE_RST : cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transfer completion
  // ----------------------------------------------------------------
  // controller samples three cycles late
  // Pin register plus synchroniser delay the far side's answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lat_dly_q <= 3'h0;
      crx_q     <= spi_pkg::DATA_RST;
    end else begin
      lat_dly_q <= {lat_dly_q[1:0], c_latch};
      if (lat_dly_q[2]) begin
        crx_q <= {crx_q[6:0], din};
      end
    end
  end

  // only a completion inside wait is deferred
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q <= spi_pkg::BIT_RST;
    end else if (p_done && frz) begin
      pend_q <= 1'b1;
    end else if (!frz) begin
      pend_q <= 1'b0;
    end
  end

  assign done_set = c_done || (p_done && !frz) || (pend_q && !frz);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_buf_q <= spi_pkg::DATA_RST;
    end else if (c_done) begin
      rx_buf_q <= crx_q;
    end else if (p_done && !frz) begin
      // Final bit enters the shifter at this same edge
      rx_buf_q <= {sreg_q[6:0], latch_q};
    end else if (pend_q && !frz) begin
      rx_buf_q <= sreg_q;
    end
  end

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q      <= spi_pkg::BIT_RST;
      done_seen_q <= spi_pkg::BIT_RST;
    end else begin
      if (done_set) begin
        done_q <= 1'b1;
      end else if (rd_data && done_seen_q) begin
        done_q <= 1'b0;
      end
      if (rd_status && done_q) begin
        done_seen_q <= 1'b1;
      end else if (rd_data || !done_q) begin
        done_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    pins_d.sck     = sck_q;
    pins_d.sck_oe  = en_q && ctrl_q;
    pins_d.mosi    = sreg_q[7];
    pins_d.mosi_oe = en_q && ctrl_q && (!sws_q || swoe_q);
    pins_d.miso    = sreg_q[7];
    // peripheral output buffer off after a fault
    pins_d.miso_oe = p_sel && !fault_q && (!sws_q || swoe_q);
    pins_d.ss_n    = (st_q == spi_pkg::ST_IDLE);
    pins_d.ss_n_oe = en_q && ctrl_q && sso_q && mfen_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pins <= '{sck: 1'b0, sck_oe: 1'b0, mosi: 1'b0, mosi_oe: 1'b0,
                miso: 1'b0, miso_oe: 1'b0, ss_n: 1'b1, ss_n_oe: 1'b0};
    end else begin
      pins <= pins_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_select_low_busy: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(st_q != spi_pkg::ST_IDLE) && pins.ss_n_oe) |-> !pins.ss_n)
    else $error("select not low during transfer");

  chk_select_out_gate: assert property (@(posedge clk) disable iff (!reset_n)
    pins.ss_n_oe |-> $past(ctrl_q && sso_q && mfen_q))
    else $error("select driven without both enables");

  chk_fault_sets: assert property (@(posedge clk) disable iff (!reset_n)
    fault_set |=> (fault_q && !ctrl_q))
    else $error("select low did not raise fault");

  chk_fault_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (!fault_q && (!mfen_q || !ctrl_q)) |=> !fault_q)
    else $error("fault raised while detection is off");

  chk_fault_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(fault_q) |-> ##1 (!pins.sck_oe && !pins.mosi_oe && !pins.miso_oe))
    else $error("outputs still driven after fault");

  chk_fault_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_c1 && fault_seen_q && !fault_set) |=> !fault_q)
    else $error("fault not cleared by read then write");

  chk_wait_defer: assert property (@(posedge clk) disable iff (!reset_n)
    (p_done && frz && !done_q) |=> (!done_q && pend_q))
    else $error("done raised inside wait");

  chk_sixteen_edges: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == spi_pkg::ST_TRAIL) |-> (cnt_q == 5'h10))
    else $error("controller transfer did not span sixteen edges");

  cov_ctrl_done: cover property (@(posedge clk) disable iff (!reset_n) c_done);
  cov_fault:     cover property (@(posedge clk) disable iff (!reset_n) $rose(fault_q));
  cov_deferred:  cover property (@(posedge clk) disable iff (!reset_n) pend_q && !frz);

endmodule : spi_port

// *** tb/serial_partner.sv ***
// Purpose: External peripheral answering the port in phase-zero format
// Assumes: Idle-low serial clock, MSB first
// Notes:   Released data line shows the inverse of its last value
`timescale 1ns/1ps
module serial_partner (
  // Clock
  input  wire logic       clk,
  // Serial link
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  // Bytes
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh_q;
  logic       lat_q;
  logic       last_q;
  initial sh_q = 8'h00;
  initial last_q = 1'b0;
  always @(negedge ss_n) sh_q = tx_byte;
  always @(posedge sck) if (!ss_n) lat_q = mosi;
  always @(negedge sck) if (!ss_n) begin
    sh_q = {sh_q[6:0], lat_q};
    rx_byte = sh_q;
  end
  always @(posedge clk) if (!ss_n) last_q <= sh_q[7];
  assign miso = ss_n ? !last_q : sh_q[7];
endmodule : serial_partner

// *** tb/test_spi_port.sv ***
// Purpose: Self-checking bench for the serial port
// Assumes: Partner acts as the selected peripheral
// Notes:   Wire levels resolved here from all enables
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_spi_port;
  logic              clk, reset_n, read, write, cpu_wait, ss_force, sck_p, ss_bad;
  logic [4:0]        address;
  logic [31:0]       writedata, readdata, q;
  logic              waitrequest, sck_w, ss_w, mosi_w, miso_w, miso_p;
  logic [7:0]        p_tx, p_rx;
  spi_pkg::pin_in_s  pin_i;
  spi_pkg::pin_out_s pins;
  int                cyc, last, gap, edges, miscompares, num_checks;
  spi_port u_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cpu_wait(cpu_wait), .pins_in(pin_i), .pins(pins));
  serial_partner u_peer (.clk(clk), .sck(sck_w), .ss_n(ss_w), .mosi(mosi_w),
    .miso(miso_p), .tx_byte(p_tx), .rx_byte(p_rx));
  // Pull-down on clock, pull-ups on select and mosi
  assign sck_w  = pins.sck_oe ? pins.sck : 1'b0;
  assign ss_w   = pins.ss_n_oe ? pins.ss_n : !ss_force;
  assign mosi_w = pins.mosi_oe ? pins.mosi : 1'b1;
  assign miso_w = pins.miso_oe ? pins.miso : miso_p;
  assign pin_i  = '{sck: sck_w, ss_n: ss_w, mosi: mosi_w, miso: miso_w};
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  // Edge monitor and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sck_p <= sck_w;
    if (sck_w !== sck_p) begin
      edges <= edges + 1;
      gap <= cyc - last;
      last <= cyc;
      if (ss_w !== 1'b0) ss_bad <= 1'b1;
    end
    if (cyc > 30000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic bus(input int wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= (wr != 0);
    read <= (wr == 0);
    // Only the hang limit ends a lost answer
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic fault_case;
    bus(1, spi_pkg::OFS_CTRL1, 32'h50, q);
    bus(1, spi_pkg::OFS_CTRL2, 32'h00, q);
    ss_force <= 1'b1;
    repeat (10) @(posedge clk);
    bus(0, spi_pkg::OFS_STATUS, 0, q);
    `CHK(q[spi_pkg::SR_FAULT], 1'b0)
    bus(1, spi_pkg::OFS_CTRL2, 32'h10, q);
    repeat (10) @(posedge clk);
    bus(0, spi_pkg::OFS_STATUS, 0, q);
    `CHK(q[spi_pkg::SR_FAULT], 1'b1)
    `CHK({pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 3'b000)
    bus(0, spi_pkg::OFS_CTRL1, 0, q);
    `CHK(q[spi_pkg::C1_CONTROLLER], 1'b0)
    ss_force <= 1'b0;
    bus(1, spi_pkg::OFS_CTRL1, 32'h52, q);
    bus(0, spi_pkg::OFS_STATUS, 0, q);
    `CHK(q[spi_pkg::SR_FAULT], 1'b0)
  endtask : fault_case
  task automatic xfer(input logic [7:0] b, input int div, input logic [7:0] d, r,
                      input logic pause);
    int n;
    p_tx = r;
    bus(1, spi_pkg::OFS_BAUD, {24'h0, b}, q);
    edges <= 0;
    ss_bad <= 1'b0;
    bus(1, spi_pkg::OFS_DATA, {24'h0, d}, q);
    if (pause) begin
      n = 0;
      while (edges < 4 && n < 100) begin
        @(posedge clk);
        n++;
      end
      cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      n = edges;
      repeat (20) @(posedge clk);
      `CHK(edges, n)
      cpu_wait <= 1'b0;
    end
    n = 0;
    do begin
      bus(0, spi_pkg::OFS_STATUS, 0, q);
      n++;
    end while (q[spi_pkg::SR_DONE] !== 1'b1 && n < 300);
    bus(0, spi_pkg::OFS_DATA, 0, q);
    `CHK(q[7:0], r)
    `CHK(p_rx, d)
    `CHK(edges, 16)
    `CHK(gap, div / 2)
    `CHK(ss_bad, 1'b0)
    repeat (20) @(posedge clk);
    `CHK(edges, 16)
    `CHK(ss_w, 1'b1)
  endtask : xfer
  initial begin
    {read, write, cpu_wait, ss_force, sck_p, ss_bad} = 6'h00;
    {address, writedata, p_tx} = 45'h0;
    {cyc, last, gap, edges, miscompares, num_checks} = 192'h0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, spi_pkg::OFS_BAUD, 0, q);
    `CHK(q, 32'h0)
    bus(0, 5'h14, 0, q);
    `CHK(q, 32'h0)
    bus(1, spi_pkg::OFS_BAUD, 32'h35, q);
    bus(0, spi_pkg::OFS_BAUD, 0, q);
    `CHK(q, 32'h35)
    fault_case();
    xfer(8'h00, 2, 8'hA5, 8'h3C, 1'b0);
    xfer(8'h01, 4, 8'h81, 8'h7E, 1'b0);
    xfer(8'h02, 8, 8'h5A, 8'hC3, 1'b0);
    xfer(8'h11, 8, 8'h0F, 8'hF0, 1'b0);
    xfer(8'h21, 12, 8'hFF, 8'h01, 1'b0);
    bus(1, spi_pkg::OFS_CTRL2, 32'h12, q);
    xfer(8'h01, 4, 8'h96, 8'h69, 1'b1);
    complete_run();
  end
endmodule : test_spi_port
